// *** rtl/rcwd_pkg.sv ***
// rcwd_pkg: constants of the radio control word decoder.
// assumes the serial word arrives b0 first, address in b13..b15 (b13 msb).
package rcwd_pkg;

  localparam int WORD_W = 16;
  localparam int ADDR_W = 3;
  localparam int CNT_W = 5;
  localparam int DAC_W = 8;
  localparam int SYNC_W = 14;

  // address codes, b13 b14 b15
  localparam logic [2:0] ADDR_POL = 3'h1;
  localparam logic [2:0] ADDR_MODE = 3'h2;
  localparam logic [2:0] ADDR_SECOND = 3'h3;
  localparam logic [2:0] ADDR_FIRST = 3'h4;
  localparam logic [2:0] ADDR_DAC = 3'h5;

  // bit bN of a word sits at shift index 15-N
  localparam int POS_ADDR_HI = 2;
  localparam int POS_FIRST_POL = 9;
  localparam int POS_SECOND_POL = 8;
  localparam int POS_WIDE_POL = 5;
  localparam int POS_TX = 15;
  localparam int POS_RX = 14;
  localparam int POS_OVERRIDE = 13;
  localparam int POS_DAC_EN = 12;
  localparam int POS_STROBE_EN = 11;
  localparam int POS_COMP_EN = 10;
  localparam int POS_FIRST_CUR_MSB = 9;
  localparam int POS_FIRST_CUR_LSB = 8;
  localparam int POS_SECOND_CUR_MSB = 7;
  localparam int POS_SECOND_CUR_LSB = 6;
  localparam int POS_CAL = 5;
  localparam int POS_WIDE_MODE = 4;
  localparam int POS_SECOND_MAIN_HI = 15;
  localparam int POS_SECOND_MAIN_LO = 11;
  localparam int POS_SECOND_SWAL_HI = 10;
  localparam int POS_SECOND_SWAL_LO = 7;
  localparam int POS_REF_HI = 6;
  localparam int POS_REF_LO = 4;
  localparam int POS_FIRST_MAIN_HI = 15;
  localparam int POS_FIRST_MAIN_LO = 10;
  localparam int POS_FIRST_SWAL_HI = 9;
  localparam int POS_FIRST_SWAL_LO = 4;
  localparam int POS_DAC_HI = 11;
  localparam int POS_DAC_LO = 4;

  // power-up values
  localparam logic RST_POL = 1'h1;
  localparam logic [11:0] RST_MODE_WORD = 12'h17F;
  localparam logic [4:0] RST_SECOND_MAIN = 5'h10;
  localparam logic [3:0] RST_SECOND_SWAL = 4'hC;
  localparam logic [2:0] RST_REF_CODE = 3'h1;
  localparam logic [5:0] RST_FIRST_MAIN = 6'h36;
  localparam logic [5:0] RST_FIRST_SWAL = 6'h14;
  localparam logic [7:0] RST_DAC = 8'h00;

  // pump currents in microamps per two-bit code
  localparam logic [11:0] CUR_UA_0 = 12'h0FA;
  localparam logic [11:0] CUR_UA_1 = 12'h1F4;
  localparam logic [11:0] CUR_UA_2 = 12'h3E8;
  localparam logic [11:0] CUR_UA_3 = 12'h7D0;

  // reference ratios
  localparam logic [5:0] REF_DIV_0 = 6'h10;
  localparam logic [5:0] REF_DIV_1 = 6'h20;
  localparam logic [5:0] REF_DIV_2 = 6'h14;
  localparam logic [5:0] REF_DIV_3 = 6'h28;

  localparam logic [5:0] SECOND_PRESCALE = 6'h0E;
  localparam logic [5:0] FIRST_PRESCALE = 6'h28;
  localparam int CAL_TONE_KHZ = 8000;

  typedef enum logic [2:0] {
    RCWD_OFF = 3'b001,
    RCWD_RX = 3'b010,
    RCWD_TX = 3'b100
  } rcwd_mode_t;

endpackage : rcwd_pkg

// *** rtl/rcwd_sync.sv ***
// rcwd_sync: two-flop synchronisers with edge pulses, one per bit.
// assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module rcwd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
        prev_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_in[i];
        sync_q[i] <= meta_q[i];
        prev_q[i] <= sync_q[i];
      end
    end
    assign level[i] = sync_q[i];
    assign rise[i] = sync_q[i] & ~prev_q[i];
    assign fall[i] = ~sync_q[i] & prev_q[i];
  end
endmodule : rcwd_sync

// *** rtl/rcwd_top.sv ***
// rcwd_top: decodes serial control words of the radio front end.
// assumes a controller on the three-wire bus, mode pins and strobe pin;
// all pins are asynchronous and are sampled through two flops.
// Function
// (RULE1) override clear: mode follows parallel pins
// (RULE2) override set: parallel mode pins ignored
// (RULE3) serial mode bits: 01 rx, 10 tx, else off
// (RULE4) polarity bit 1 pumps high, 0 low
// (RULE5) dac and comparator enables act independently
// (RULE6) strobe enable 0: only enable pin counts
// (RULE7) strobe enable 1: both pins frame data
// (RULE8) strobe rising edge loads dac, address ignored
// (RULE9) controller never holds both pins low
// (RULE10) first pump current 0.25/0.5/1/2 mA
// (RULE11) second pump current 0.25/0.5/1/2 mA
// (RULE12) controller should pick current codes 10/11
// (RULE13) calibration bit 1 gates tone in standby
// (RULE14) calibration bit 0 suppresses the tone
// (RULE15) wideband mode: 1 dual pfd+xor, 0 xor
// (RULE16) second divide is 14 main plus swallow
// (RULE17) reference code selects 16, 32, 20, 40
// (RULE18) first divide is 40 main plus swallow
// (RULE19) dac word sets threshold and scaled output
// (RULE20) flag high when level exceeds dac threshold
// (RULE21) fields change only after complete word
`timescale 1ns/1ps
module rcwd_top
  import rcwd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_en_n,
  input wire logic dac_strobe_pin_n,
  input wire logic transmit_select_pin,
  input wire logic receive_select_pin,
  input wire logic [rcwd_pkg::DAC_W-1:0] signal_level,
  output logic tx_on,
  output logic rx_on,
  output logic standby,
  output logic serial_override,
  output logic first_pump_polarity,
  output logic second_pump_polarity,
  output logic wideband_pump_polarity,
  output logic dac_enable,
  output logic comparator_enable,
  output logic dac_strobe_enable,
  output logic first_current_msb,
  output logic first_current_lsb,
  output logic second_current_msb,
  output logic second_current_lsb,
  output logic [11:0] first_pump_current_ua,
  output logic [11:0] second_pump_current_ua,
  output logic cal_tone_enable,
  output logic wideband_detector_mode,
  output logic [4:0] second_main_count,
  output logic [3:0] second_swallow_count,
  output logic [5:0] first_main_count,
  output logic [5:0] first_swallow_count,
  output logic [5:0] ref_ratio,
  output logic [8:0] second_divide,
  output logic [11:0] first_divide,
  output logic [rcwd_pkg::DAC_W-1:0] dac_value,
  output logic [rcwd_pkg::DAC_W-1:0] scaled_dac_output,
  output logic signal_threshold_flag
);
  import rcwd_pkg::*;

  logic [SYNC_W-1:0] pin_async;
  logic [SYNC_W-1:0] pin_lvl;
  logic [SYNC_W-1:0] pin_rise;
  logic [SYNC_W-1:0] pin_fall;

  // enable and strobe enter inverted: reset level is idle, no false edge
  assign pin_async = {signal_level, receive_select_pin,
                      transmit_select_pin, ~dac_strobe_pin_n,
                      ~ser_en_n, ser_data, ser_clk};

  rcwd_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(pin_async),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  logic sclk_rise;
  logic sdata;
  logic en_n_s;
  logic en_rise;
  logic en_fall;
  logic strobe_n_s;
  logic strobe_rise;
  logic strobe_fall;
  logic ts_s;
  logic rs_s;
  logic [DAC_W-1:0] level_s;

  assign sclk_rise = pin_rise[0];
  assign sdata = pin_lvl[1];
  assign en_n_s = ~pin_lvl[2];
  assign en_rise = pin_fall[2];
  assign en_fall = pin_rise[2];
  assign strobe_n_s = ~pin_lvl[3];
  assign strobe_rise = pin_fall[3];
  assign strobe_fall = pin_rise[3];
  assign ts_s = pin_lvl[4];
  assign rs_s = pin_lvl[5];
  assign level_s = pin_lvl[13:6];

  // settings held by the decoder
  logic [WORD_W-1:0] sr_q;
  logic [CNT_W-1:0] cnt_q;
  logic first_pol_q;
  logic second_pol_q;
  logic wide_pol_q;
  logic tx_bit_q;
  logic rx_bit_q;
  logic override_q;
  logic dac_en_q;
  logic strobe_en_q;
  logic comp_en_q;
  logic [1:0] first_cur_q;
  logic [1:0] second_cur_q;
  logic cal_q;
  logic wide_mode_q;
  logic [4:0] second_main_q;
  logic [3:0] second_swal_q;
  logic [2:0] ref_code_q;
  logic [5:0] first_main_q;
  logic [5:0] first_swal_q;
  logic [DAC_W-1:0] dac_q;

  logic strobe_active;
  logic frame_active;
  logic frame_start;
  logic word_full;
  logic word_done;
  logic strobe_load;
  logic [ADDR_W-1:0] addr;

  // the strobe pin frames and loads only while strobe enable is set
  assign strobe_active = strobe_en_q & ~strobe_n_s; // [RULE6] [RULE7]
  assign frame_active = ~en_n_s | strobe_active; // [RULE7]
  assign frame_start = en_fall | (strobe_en_q & strobe_fall); // [RULE7]
  assign word_full = cnt_q >= CNT_W'(WORD_W);
  assign word_done = en_rise & word_full; // [RULE21]
  assign strobe_load = strobe_en_q & strobe_rise & word_full; // [RULE8]
  assign addr = sr_q[POS_ADDR_HI:0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_q <= '0;
    end else if (frame_active && sclk_rise) begin
      sr_q <= {sr_q[WORD_W-2:0], sdata};
    end
  end

  // counter saturates so a long frame keeps its last sixteen bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (frame_start) begin
      cnt_q <= '0;
    end else if (frame_active && sclk_rise && !word_full) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_pol_q <= RST_POL;
      second_pol_q <= RST_POL;
      wide_pol_q <= RST_POL;
    end else if (word_done && addr == ADDR_POL) begin
      first_pol_q <= sr_q[POS_FIRST_POL]; // [RULE4]
      second_pol_q <= sr_q[POS_SECOND_POL]; // [RULE4]
      wide_pol_q <= sr_q[POS_WIDE_POL]; // [RULE4]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_bit_q <= RST_MODE_WORD[11];
      rx_bit_q <= RST_MODE_WORD[10];
      override_q <= RST_MODE_WORD[9];
      dac_en_q <= RST_MODE_WORD[8];
      strobe_en_q <= RST_MODE_WORD[7];
      comp_en_q <= RST_MODE_WORD[6];
      first_cur_q <= RST_MODE_WORD[5:4];
      second_cur_q <= RST_MODE_WORD[3:2];
      cal_q <= RST_MODE_WORD[1];
      wide_mode_q <= RST_MODE_WORD[0];
    end else if (word_done && addr == ADDR_MODE) begin
      tx_bit_q <= sr_q[POS_TX];
      rx_bit_q <= sr_q[POS_RX];
      override_q <= sr_q[POS_OVERRIDE];
      dac_en_q <= sr_q[POS_DAC_EN]; // [RULE5]
      strobe_en_q <= sr_q[POS_STROBE_EN];
      comp_en_q <= sr_q[POS_COMP_EN]; // [RULE5]
      first_cur_q <= {sr_q[POS_FIRST_CUR_MSB], sr_q[POS_FIRST_CUR_LSB]};
      second_cur_q <= {sr_q[POS_SECOND_CUR_MSB], sr_q[POS_SECOND_CUR_LSB]};
      cal_q <= sr_q[POS_CAL];
      wide_mode_q <= sr_q[POS_WIDE_MODE]; // [RULE15]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      second_main_q <= RST_SECOND_MAIN;
      second_swal_q <= RST_SECOND_SWAL;
      ref_code_q <= RST_REF_CODE;
    end else if (word_done && addr == ADDR_SECOND) begin
      second_main_q <= sr_q[POS_SECOND_MAIN_HI:POS_SECOND_MAIN_LO];
      second_swal_q <= sr_q[POS_SECOND_SWAL_HI:POS_SECOND_SWAL_LO];
      ref_code_q <= sr_q[POS_REF_HI:POS_REF_LO]; // [RULE17]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_main_q <= RST_FIRST_MAIN;
      first_swal_q <= RST_FIRST_SWAL;
    end else if (word_done && addr == ADDR_FIRST) begin
      first_main_q <= sr_q[POS_FIRST_MAIN_HI:POS_FIRST_MAIN_LO];
      first_swal_q <= sr_q[POS_FIRST_SWAL_HI:POS_FIRST_SWAL_LO];
    end
  end

  // a strobe load takes the shifted bits whatever the address says
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_q <= RST_DAC;
    end else if (strobe_load) begin
      dac_q <= sr_q[POS_DAC_HI:POS_DAC_LO]; // [RULE8]
    end else if (word_done && addr == ADDR_DAC) begin
      dac_q <= sr_q[POS_DAC_HI:POS_DAC_LO]; // [RULE19]
    end
  end

  // operating mode
  rcwd_mode_t mode_d;
  rcwd_mode_t mode_q;

  always_comb begin
    mode_d = RCWD_OFF;
    if (override_q) begin
      case ({tx_bit_q, rx_bit_q}) // [RULE2] [RULE3]
        2'b01: mode_d = RCWD_RX;
        2'b10: mode_d = RCWD_TX;
        default: mode_d = RCWD_OFF;
      endcase
    end else begin
      // both pins high is treated as standby
      case ({ts_s, rs_s}) // [RULE1]
        2'b01: mode_d = RCWD_RX;
        2'b10: mode_d = RCWD_TX;
        default: mode_d = RCWD_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= RCWD_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_comb begin
    tx_on = 1'b0;
    rx_on = 1'b0;
    standby = 1'b0;
    case (mode_q)
      RCWD_TX: tx_on = 1'b1;
      RCWD_RX: rx_on = 1'b1;
      RCWD_OFF: standby = 1'b1;
      default: standby = 1'b1;
    endcase
  end

  function automatic logic [11:0] cur_ua(input logic [1:0] code);
    case (code)
      2'b00: cur_ua = CUR_UA_0;
      2'b01: cur_ua = CUR_UA_1;
      2'b10: cur_ua = CUR_UA_2;
      default: cur_ua = CUR_UA_3;
    endcase
  endfunction : cur_ua

  logic [11:0] first_ua_q;
  logic [11:0] second_ua_q;
  logic [5:0] ref_ratio_q;
  logic [8:0] second_div_q;
  logic [11:0] first_div_q;
  logic flag_q;
  logic cal_tone_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_ua_q <= CUR_UA_3;
      second_ua_q <= CUR_UA_3;
    end else begin
      first_ua_q <= cur_ua(first_cur_q); // [RULE10]
      second_ua_q <= cur_ua(second_cur_q); // [RULE11]
    end
  end

  // codes with b9 set are undefined and give ratio 0
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_ratio_q <= REF_DIV_1;
    end else begin
      case (ref_code_q) // [RULE17]
        3'h0: ref_ratio_q <= REF_DIV_0;
        3'h1: ref_ratio_q <= REF_DIV_1;
        3'h2: ref_ratio_q <= REF_DIV_2;
        3'h3: ref_ratio_q <= REF_DIV_3;
        default: ref_ratio_q <= '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      second_div_q <= '0;
      first_div_q <= '0;
    end else begin
      second_div_q <= 9'(SECOND_PRESCALE) * 9'(second_main_q) +
                      9'(second_swal_q); // [RULE16]
      first_div_q <= 12'(FIRST_PRESCALE) * 12'(first_main_q) +
                     12'(first_swal_q); // [RULE18]
    end
  end

  // tone gate only; the tone itself comes from the analogue divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_tone_q <= 1'b0;
    end else begin
      cal_tone_q <= cal_q & (mode_d == RCWD_OFF); // [RULE13] [RULE14]
    end
  end

  // flag reads zero while the comparator is switched off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= comp_en_q & (level_s > dac_q); // [RULE20]
    end
  end

  assign serial_override = override_q;
  assign first_pump_polarity = first_pol_q;
  assign second_pump_polarity = second_pol_q;
  assign wideband_pump_polarity = wide_pol_q;
  assign dac_enable = dac_en_q;
  assign comparator_enable = comp_en_q;
  assign dac_strobe_enable = strobe_en_q;
  assign first_current_msb = first_cur_q[1];
  assign first_current_lsb = first_cur_q[0];
  assign second_current_msb = second_cur_q[1];
  assign second_current_lsb = second_cur_q[0];
  assign first_pump_current_ua = first_ua_q;
  assign second_pump_current_ua = second_ua_q;
  assign cal_tone_enable = cal_tone_q;
  assign wideband_detector_mode = wide_mode_q;
  assign second_main_count = second_main_q;
  assign second_swallow_count = second_swal_q;
  assign first_main_count = first_main_q;
  assign first_swallow_count = first_swal_q;
  assign ref_ratio = ref_ratio_q;
  assign second_divide = second_div_q;
  assign first_divide = first_div_q;
  assign dac_value = dac_q;
  // scaled output is the dac code, zero while the dac is off
  assign scaled_dac_output = dac_en_q ? dac_q : '0; // [RULE19] [RULE5]
  assign signal_threshold_flag = flag_q;

endmodule : rcwd_top

// *** sim/rcwd_ctrl_model.sv ***
// rcwd_ctrl_model: baseband controller on the three-wire bus.
// assumes clk is the system clock; drives at its falling edge.
`timescale 1ns/1ps
module rcwd_ctrl_model (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_en_n,
  output logic dac_strobe_pin_n
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_en_n = 1'b1;
    dac_strobe_pin_n = 1'b1;
  end
  // serial clock stands still low between frames; 400 ns period
  task automatic send(logic [15:0] w, int n, logic stb);
    @(negedge clk);
    if (stb) dac_strobe_pin_n = 1'b0; // enable stays high
    else ser_en_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      ser_data = w[i];
      repeat (4) @(negedge clk);
      ser_clk = 1'b1;
      repeat (4) @(negedge clk);
      ser_clk = 1'b0;
    end
    repeat (4) @(negedge clk);
    ser_en_n = 1'b1;
    dac_strobe_pin_n = 1'b1;
    ser_data = ~ser_data; // released line shows no stale bit
  endtask : send
endmodule : rcwd_ctrl_model

// *** sim/rcwd_top_sva.sv ***
// rcwd_top_sva: port-level checks of the control word decoder.
// assumes it is bound to rcwd_top and sees only its ports.
`timescale 1ns/1ps
module rcwd_top_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ser_en_n,
  input wire logic transmit_select_pin,
  input wire logic receive_select_pin,
  input wire logic [7:0] signal_level,
  input wire logic tx_on,
  input wire logic rx_on,
  input wire logic standby,
  input wire logic serial_override,
  input wire logic dac_enable,
  input wire logic comparator_enable,
  input wire logic dac_strobe_enable,
  input wire logic first_current_msb,
  input wire logic first_current_lsb,
  input wire logic second_current_msb,
  input wire logic second_current_lsb,
  input wire logic [11:0] first_pump_current_ua,
  input wire logic [11:0] second_pump_current_ua,
  input wire logic cal_tone_enable,
  input wire logic [4:0] second_main_count,
  input wire logic [3:0] second_swallow_count,
  input wire logic [5:0] first_main_count,
  input wire logic [5:0] first_swallow_count,
  input wire logic [8:0] second_divide,
  input wire logic [11:0] first_divide,
  input wire logic [7:0] dac_value,
  input wire logic [7:0] scaled_dac_output,
  input wire logic signal_threshold_flag
);
  // a commit lands a few cycles after the enable rises, so wait 12
  wire quiet = serial_override && ser_en_n;
  wire idle_dac = !dac_strobe_enable && ser_en_n;
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  mode_onehot_a:
    assert property ($onehot({tx_on, rx_on, standby}))
    else $error("mode outputs not one-hot");
  pins_mode_a:
    assert property ((!serial_override && transmit_select_pin &&
      !receive_select_pin)[*8] |-> tx_on)
    else $error("transmit pin not followed");
  pins_ignored_a:
    assert property (quiet[*8] ##1 quiet[*4] |-> $stable({tx_on, rx_on}))
    else $error("mode moved under serial override");
  first_current_a:
    assert property ($stable({first_current_msb, first_current_lsb}) |->
      first_pump_current_ua == 12'h0FA << {first_current_msb,
      first_current_lsb})
    else $error("first pump current wrong");
  second_current_a:
    assert property ($stable({second_current_msb, second_current_lsb}) |->
      second_pump_current_ua == 12'h0FA << {second_current_msb,
      second_current_lsb})
    else $error("second pump current wrong");
  second_divide_a:
    assert property ($past(arst_n) && $stable({second_main_count,
      second_swallow_count}) |-> second_divide ==
      9'(14 * second_main_count + second_swallow_count))
    else $error("second divide wrong");
  first_divide_a:
    assert property ($past(arst_n) && $stable({first_main_count,
      first_swallow_count}) |-> first_divide ==
      12'(40 * first_main_count + first_swallow_count))
    else $error("first divide wrong");
  scaled_out_a:
    assert property ($stable({dac_enable, dac_value}) |->
      scaled_dac_output == (dac_enable ? dac_value : 8'h00))
    else $error("scaled output wrong");
  flag_level_a:
    assert property (($stable(signal_level) && $stable(dac_value) &&
      comparator_enable)[*8] |->
      signal_threshold_flag == (signal_level > dac_value))
    else $error("threshold flag wrong");
  cal_gate_a:
    assert property (!standby && !$past(standby) |-> !cal_tone_enable)
    else $error("tone outside standby");
  whole_word_a:
    assert property ((!ser_en_n)[*8] |-> $stable({dac_value,
      first_main_count, second_main_count, serial_override}))
    else $error("field moved mid-frame");
  strobe_off_a:
    assert property (idle_dac[*8] ##1 idle_dac[*4] |-> $stable(dac_value))
    else $error("dac loaded with strobe disabled");
endmodule : rcwd_top_sva

bind rcwd_top rcwd_top_sva i_rcwd_top_sva (
  .clk, .arst_n, .ser_en_n, .transmit_select_pin, .receive_select_pin,
  .signal_level, .tx_on, .rx_on, .standby, .serial_override, .dac_enable,
  .comparator_enable, .dac_strobe_enable, .first_current_msb,
  .first_current_lsb, .second_current_msb, .second_current_lsb,
  .first_pump_current_ua, .second_pump_current_ua, .cal_tone_enable,
  .second_main_count, .second_swallow_count, .first_main_count,
  .first_swallow_count, .second_divide, .first_divide, .dac_value,
  .scaled_dac_output, .signal_threshold_flag
);

// *** sim/test_rcwd_top.sv ***
// test_rcwd_top: self-checking bench of the control word decoder.
// assumes rcwd_top, its checker and the controller model are compiled.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module test_rcwd_top;
  import rcwd_pkg::*;
  int n_fail = 0;
  int n_compared = 0;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic transmit_select_pin = 1'b0;
  logic receive_select_pin = 1'b0;
  logic [7:0] signal_level = 8'h00;
  logic ser_clk, ser_data, ser_en_n, dac_strobe_pin_n;
  logic tx_on, rx_on, standby, serial_override, first_pump_polarity;
  logic second_pump_polarity, wideband_pump_polarity, dac_enable;
  logic comparator_enable, dac_strobe_enable, first_current_msb;
  logic first_current_lsb, second_current_msb, second_current_lsb;
  logic cal_tone_enable, wideband_detector_mode, signal_threshold_flag;
  logic [11:0] first_pump_current_ua, second_pump_current_ua, first_divide;
  logic [4:0] second_main_count;
  logic [3:0] second_swallow_count;
  logic [5:0] first_main_count, first_swallow_count, ref_ratio;
  logic [8:0] second_divide;
  logic [7:0] dac_value, scaled_dac_output;
  logic [1:0] c;
  logic [2:0] md;
  logic [5:0] rr [4] = '{6'h10, 6'h20, 6'h14, 6'h28};

  rcwd_ctrl_model i_rcwd_ctrl_model (.clk, .ser_clk, .ser_data, .ser_en_n,
    .dac_strobe_pin_n);
  rcwd_top i_rcwd_top (.clk, .arst_n, .ser_clk, .ser_data, .ser_en_n,
    .dac_strobe_pin_n, .transmit_select_pin, .receive_select_pin,
    .signal_level, .tx_on, .rx_on, .standby, .serial_override,
    .first_pump_polarity, .second_pump_polarity, .wideband_pump_polarity,
    .dac_enable, .comparator_enable, .dac_strobe_enable, .first_current_msb,
    .first_current_lsb, .second_current_msb, .second_current_lsb,
    .first_pump_current_ua, .second_pump_current_ua, .cal_tone_enable,
    .wideband_detector_mode, .second_main_count, .second_swallow_count,
    .first_main_count, .first_swallow_count, .ref_ratio, .second_divide,
    .first_divide, .dac_value, .scaled_dac_output, .signal_threshold_flag);

  initial begin
    forever #25 clk = ~clk;
  end

  // fields go b0 first; address b13..b15 with b13 as msb
  function automatic logic [15:0] wd(logic [2:0] a, logic [11:0] f);
    for (int i = 0; i < 12; i++) wd[i] = f[11 - i];
    wd[15:12] = {a[0], a[1], a[2], 1'b0};
  endfunction : wd

  task automatic put(logic [2:0] a, logic [11:0] f, int n = 16,
    logic stb = 1'b0);
    i_rcwd_ctrl_model.send(wd(a, f), n, stb);
    repeat (10) @(negedge clk);
  endtask : put

  task automatic conclude;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (40000) @(negedge clk);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK({first_pump_polarity, second_pump_polarity}, 2'h3)
    `CHK({dac_enable, comparator_enable, dac_strobe_enable}, 3'h6)
    `CHK(serial_override, 1'b0)
    `CHK(cal_tone_enable, 1'b1)
    `CHK(ref_ratio, 6'h20)
    `CHK(second_divide, 9'h0EC)
    `CHK(first_divide, 12'h884)
    transmit_select_pin = 1'b1;
    repeat (8) @(negedge clk);
    `CHK({tx_on, rx_on, standby}, 3'h4)
    put(ADDR_MODE, 12'h97F);
    transmit_select_pin = 1'b0;
    receive_select_pin = 1'b1;
    repeat (8) @(negedge clk);
    `CHK({tx_on, rx_on, standby}, 3'h2)
    transmit_select_pin = 1'b1;
    repeat (8) @(negedge clk);
    `CHK({tx_on, rx_on, standby}, 3'h1)
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      md = (c == 2'h1) ? 3'h2 : (c == 2'h2) ? 3'h4 : 3'h1;
      put(ADDR_MODE, {c, 1'b1, c[0], 1'b0, c[1], c, ~c, c[0], c[1]});
      `CHK({tx_on, rx_on, standby}, md)
      `CHK(serial_override, 1'b1)
      `CHK(first_pump_current_ua, 12'h0FA << c)
      `CHK(second_pump_current_ua, 12'h0FA << ~c)
      `CHK({dac_enable, comparator_enable}, {c[0], c[1]})
      `CHK(wideband_detector_mode, c[1])
      `CHK(cal_tone_enable, c[0] & md[0])
    end
    for (int k = 0; k < 2; k++) begin
      md = k ? 3'h5 : 3'h2;
      put(ADDR_POL, {6'h00, md[2], md[1], 2'h0, md[0], 1'b0});
      `CHK({first_pump_polarity, second_pump_polarity}, md[2:1])
      `CHK(wideband_pump_polarity, md[0])
    end
    for (int r = 0; r < 4; r++) begin
      put(ADDR_SECOND, {5'(31 - r), 4'(15 - r), 3'(r)});
      `CHK(ref_ratio, rr[r])
      `CHK(second_divide, 9'(14 * (31 - r) + 15 - r))
    end
    put(ADDR_FIRST, 12'hFFF);
    `CHK({first_main_count, first_swallow_count}, 12'hFFF)
    `CHK(first_divide, 12'hA17)
    put(ADDR_DAC, 12'h080);
    signal_level = 8'h80;
    repeat (8) @(negedge clk);
    `CHK({dac_value, scaled_dac_output}, 16'h8080)
    `CHK(signal_threshold_flag, 1'b0)
    signal_level = 8'h81;
    repeat (8) @(negedge clk);
    `CHK(signal_threshold_flag, 1'b1)
    put(ADDR_DAC, 12'h0A5, 15);
    `CHK(dac_value, 8'h80)
    put(3'h6, 12'h0A5);
    `CHK(dac_value, 8'h80)
    put(ADDR_POL, 12'h0A5, 16, 1'b1);
    `CHK(dac_value, 8'h80)
    // pump codes kept at 11, the usual choice for a clean detector
    put(ADDR_MODE, 12'h3FF);
    put(ADDR_POL, 12'h03C, 16, 1'b1);
    `CHK(dac_value, 8'h3C)
    put(ADDR_DAC, 12'h0C3);
    `CHK(dac_value, 8'hC3)
    // a reset in mid-run must bring back the power-up settings
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK({serial_override, dac_value}, 9'h000)
    `CHK(dac_strobe_enable, 1'b0)
    conclude();
  end
endmodule : test_rcwd_top
